//--- pmhp_pkg.sv
package pmhp_pkg;

	// host port widths
	localparam int DATA_W     = 10;
	localparam int BYTE_W     = 8;
	localparam int INDEX_W    = 8;
	localparam int CTRL_COUNT = 9;
	localparam int RAM_DEPTH  = 256;

	// register-select codes, {reg_select_hi, reg_select_lo}
	localparam logic [1:0] SEL_INDEX   = 2'h0;
	localparam logic [1:0] SEL_COLOUR  = 2'h1;
	localparam logic [1:0] SEL_CONTROL = 2'h2;
	localparam logic [1:0] SEL_MODE    = 2'h3;

	// mode_control fields and reset value
	localparam int         MODE_RES_BIT = 1;
	localparam int         MODE_BUS_BIT = 2;
	localparam logic [7:0] MODE_RESET   = 8'hFF;

	// control registers, slot 0 in the low byte
	localparam logic [71:0] CTRL_RESET = 72'h000000000000FFFF00;

	// colour pointer
	typedef enum logic [1:0] {COLOUR_RED, COLOUR_GREEN, COLOUR_BLUE} pmhp_colour_type;

	// pixel mapping modes
	typedef enum logic [1:0] {PIX_PSEUDO, PIX_TRUE15_A, PIX_TRUE15_B, PIX_TRUE24} pmhp_pixel_mode_type;

	// host pins as seen at the device
	typedef struct packed {
		logic              ce_n;
		logic              read_not_write;
		logic [1:0]        sel;
		logic [DATA_W-1:0] data;
	} pmhp_bus_type;

	// one palette word, ten bits per colour
	typedef struct packed {
		logic [9:0] red;
		logic [9:0] green;
		logic [9:0] blue;
	} pmhp_rgb_type;

	// eight-bit pixel inputs, also used for look-up indices
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} pmhp_pixel_type;

endpackage

//--- pmhp_colour_ram.sv
`timescale 1ns/1ns
module pmhp_colour_ram #(
	parameter int DEPTH  = 256,
	parameter int ADDR_W = 8,
	parameter int WORD_W = 30
) (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic                        write_enable,
	input  wire logic [ADDR_W-1:0]           write_addr,
	input  wire logic [WORD_W-1:0]           write_word,
	input  wire logic [3:0][ADDR_W-1:0]      read_addr,
	output logic      [3:0][WORD_W-1:0]      read_word
);

	initial
	begin
		if (DEPTH != (1 << ADDR_W))
			$error("depth must fill the address space");
	end

	logic [WORD_W-1:0] store [DEPTH];   // palette words

	// write port, no reset on storage
	always_ff @(posedge clock)
	begin
		if (write_enable)
			store[write_addr] <= write_word;
	end

	// registered read ports
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			read_word <= '0;
		else
			for (int i = 0; i < 4; i++)
				read_word[i] <= store[read_addr[i]];
	end

endmodule

//--- pmhp_pixel_map.sv
`timescale 1ns/1ns
module pmhp_pixel_map (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire pmhp_pkg::pmhp_pixel_mode_type pixel_mode,
	input  wire pmhp_pkg::pmhp_pixel_type      pixel_in,
	output pmhp_pkg::pmhp_pixel_type           lut_index
);

	pmhp_pkg::pmhp_pixel_type r;        // registered indices
	pmhp_pkg::pmhp_pixel_type next_r;   // next indices

	// five-bit field into locations 0 to 31
	function automatic logic [7:0] low_lane(input logic [4:0] f);
		return {3'h0, f};
	endfunction

	// per-mode mapping, unused inputs never reach an index
	always_comb
	begin
		case (pixel_mode)
			pmhp_pkg::PIX_TRUE15_A:
			begin
				next_r.red   = low_lane(pixel_in.red[7:3]);            // RL1
				next_r.green = low_lane(pixel_in.green[7:3]);          // RL1
				next_r.blue  = low_lane(pixel_in.blue[7:3]);           // RL3
			end
			pmhp_pkg::PIX_TRUE15_B:
			begin
				next_r.red   = low_lane(pixel_in.green[6:2]);          // RL2
				next_r.green = low_lane({pixel_in.green[1:0], pixel_in.red[7:5]}); // RL2
				next_r.blue  = low_lane(pixel_in.red[4:0]);            // RL3
			end
			pmhp_pkg::PIX_TRUE24:
				next_r = pixel_in;
			default:
			begin
				next_r.red   = pixel_in.red;
				next_r.green = pixel_in.red;
				next_r.blue  = pixel_in.red;
			end
		endcase
	end

	// index register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign lut_index = r;

	property p_mode_a_map;
		@(posedge clock) disable iff (rst)
		pixel_mode == pmhp_pkg::PIX_TRUE15_A |=> lut_index.red == {3'h0, $past(pixel_in.red[7:3])};
	endproperty
	a_mode_a_map: assert property (p_mode_a_map) else $error("first 15-bit mode red index wrong"); // RL1

	property p_mode_b_ignores;
		@(posedge clock) disable iff (rst)
		pixel_mode == pmhp_pkg::PIX_TRUE15_B |=> lut_index.red == {3'h0, $past(pixel_in.green[6:2])}
			&& lut_index.blue == {3'h0, $past(pixel_in.red[4:0])};
	endproperty
	a_mode_b_ignores: assert property (p_mode_b_ignores) else $error("second 15-bit mode index wrong"); // RL2

endmodule

//--- pmhp_host_port.sv
// Summary of operation
// RL1 - first 15-bit mode: upper five bits, entries 0-31
// RL2 - second 15-bit mode: red and low green
// RL3 - unused pixel inputs never affect colour
// RL4 - ten data lines, enable, two selects, direction
// RL5 - transfer format follows bus width and resolution
// RL6 - select 1,0 reaches indexed control register
// RL7 - select 0,1 reaches palette through holding registers; reads here take the entry straight from the palette
// RL8 - 1,1 mode register; 0,0 index register
// RL9 - enable strobe times latching and read drive
// RL10 - direction low writes, high reads and drives
// RL11 - port starts in ten-bit width
// RL12 - index write, then red, green, blue writes
// RL13 - pointer back to red after blue or index
// RL14 - blue write stores joined word at index
// RL15 - index steps after blue write, wraps
// RL16 - index write, then red, green, blue reads
// RL17 - index steps after blue read, wraps
// RL18 - control registers only through index register
// RL19 - ten-bit mode: colours ten bits, others eight
// RL20 - eight-bit bus: high byte then two bits
// RL21 - width bit; upper lines zero when narrow
// RL22 - resolution bit; low bits zero when clear
// RL23 - index register eight bits, read and write
// RL24 - partial colour set keeps entry unchanged
`timescale 1ns/1ns
module pmhp_host_port #(
	parameter int CTRL_COUNT = pmhp_pkg::CTRL_COUNT
) (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire pmhp_pkg::pmhp_bus_type        bus_pins,
	output logic [pmhp_pkg::DATA_W-1:0]        data_out,
	output logic                               data_oe,
	input  wire pmhp_pkg::pmhp_pixel_mode_type pixel_mode,
	input  wire pmhp_pkg::pmhp_pixel_type      pixel_in,
	output pmhp_pkg::pmhp_rgb_type             dac_out,
	output logic [7:0]                         mode_control
);

	initial
	begin
		if (CTRL_COUNT < 1 || CTRL_COUNT > pmhp_pkg::CTRL_COUNT)
			$error("control register count out of range");
	end

	// whole state of the port
	typedef struct packed {
		pmhp_pkg::pmhp_bus_type             sync1;      // first synchroniser stage
		pmhp_pkg::pmhp_bus_type             sync2;      // second synchroniser stage
		logic                               ce_prev;    // strobe one cycle back
		logic [7:0]                         mode;       // mode_control
		logic [7:0]                         index;      // palette_index
		logic [CTRL_COUNT-1:0][7:0]         ctrl;       // control registers
		pmhp_pkg::pmhp_rgb_type             hold;       // red, green, blue holding
		pmhp_pkg::pmhp_colour_type          ptr;        // colour pointer
		logic                               low_phase;  // second half of 8+2
		logic [pmhp_pkg::DATA_W-1:0]        data_out;   // read data
		logic                               data_oe;    // bus drive
		logic                               we;         // palette write pulse
		logic [7:0]                         waddr;      // palette write entry
		pmhp_pkg::pmhp_rgb_type             wdata;      // palette write word
		pmhp_pkg::pmhp_rgb_type             dac;        // colour to converters
	} pmhp_state_type;

	pmhp_state_type r;        // current state
	pmhp_state_type next_r;   // next state

	localparam logic [7:0] CTRL_LIMIT = 8'(CTRL_COUNT);

	logic                         strobe_fall;   // access begins
	logic                         strobe_rise;   // access ends
	logic                         res_ten;       // 30-bit palette words
	logic                         bus_ten;       // ten data lines
	logic                         wide;          // ten bits at once
	logic                         two_cycle;     // 8+2 format
	logic [3:0][7:0]              read_addr;     // ram read entries
	logic [3:0][29:0]             read_word;     // ram read words
	pmhp_pkg::pmhp_pixel_type     lut_index;     // mapped pixel indices
	pmhp_pkg::pmhp_rgb_type       host_word;     // entry at palette_index
	pmhp_pkg::pmhp_rgb_type       word_red;      // entry for red converter
	pmhp_pkg::pmhp_rgb_type       word_green;    // entry for green converter
	pmhp_pkg::pmhp_rgb_type       word_blue;     // entry for blue converter
	logic [9:0]                   value;         // colour being moved
	logic                         done;          // colour transfer complete

	// pick one colour out of a word
	function automatic logic [9:0] colour_of(input pmhp_pkg::pmhp_rgb_type w, input pmhp_pkg::pmhp_colour_type p);
		case (p)
			pmhp_pkg::COLOUR_RED:   return w.red;
			pmhp_pkg::COLOUR_GREEN: return w.green;
			default:                return w.blue;
		endcase
	endfunction

	// replace one colour inside a word
	function automatic pmhp_pkg::pmhp_rgb_type put_colour(input pmhp_pkg::pmhp_rgb_type w,
		input pmhp_pkg::pmhp_colour_type p, input logic [9:0] v);
		pmhp_pkg::pmhp_rgb_type o;
		o = w;
		case (p)
			pmhp_pkg::COLOUR_RED:   o.red = v;
			pmhp_pkg::COLOUR_GREEN: o.green = v;
			default:                o.blue = v;
		endcase
		return o;
	endfunction

	// drop the two low bits in eight-bit resolution
	function automatic logic [9:0] dac_lane(input logic [9:0] v, input logic ten);
		return ten ? v : {v[9:2], 2'b00};
	endfunction

	assign strobe_fall = r.ce_prev & ~r.sync2.ce_n;               // RL9
	assign strobe_rise = ~r.ce_prev & r.sync2.ce_n;               // RL9
	assign res_ten     = r.mode[pmhp_pkg::MODE_RES_BIT];          // RL22
	assign bus_ten     = r.mode[pmhp_pkg::MODE_BUS_BIT];          // RL21
	assign wide        = bus_ten & res_ten;                       // RL5
	assign two_cycle   = ~bus_ten & res_ten;                      // RL5
	assign read_addr   = {lut_index.blue, lut_index.green, lut_index.red, r.index};
	assign host_word   = read_word[0];
	assign word_red    = read_word[1];
	assign word_green  = read_word[2];
	assign word_blue   = read_word[3];

	// host access decode and palette sequencing
	always_comb
	begin
		next_r = r;
		value = 10'h000;
		done = 1'b0;
		next_r.sync1 = bus_pins;                                  // RL4
		next_r.sync2 = r.sync1;
		next_r.ce_prev = r.sync2.ce_n;
		next_r.we = 1'b0;
		// converter feed, masked to resolution
		next_r.dac.red = dac_lane(word_red.red, res_ten);         // RL22
		next_r.dac.green = dac_lane(word_green.green, res_ten);   // RL22
		next_r.dac.blue = dac_lane(word_blue.blue, res_ten);      // RL22
		// read begins: present data while strobe low
		if (strobe_fall && r.sync2.read_not_write)
		begin
			next_r.data_oe = 1'b1;                                // RL10
			case (r.sync2.sel)
				pmhp_pkg::SEL_MODE:
					next_r.data_out = {2'b00, r.mode};            // RL8
				pmhp_pkg::SEL_INDEX:
					next_r.data_out = {2'b00, r.index};           // RL23
				pmhp_pkg::SEL_CONTROL:
				begin
					// unpopulated slots read zero
					if (r.index < CTRL_LIMIT)
						next_r.data_out = {2'b00, r.ctrl[r.index[3:0]]}; // RL18
					else
						next_r.data_out = 10'h000;
				end
				default:
				begin
					value = colour_of(host_word, r.ptr);          // RL7
					if (wide)
						next_r.data_out = value;                  // RL19
					else if (two_cycle && r.low_phase)
						next_r.data_out = {8'h00, value[1:0]};    // RL20
					else
						next_r.data_out = {2'b00, value[9:2]};    // RL21
				end
			endcase
		end
		// access ends: latch writes, step reads
		if (strobe_rise)
		begin
			next_r.data_oe = 1'b0;                                // RL9
			if (!r.sync2.read_not_write)
			begin
				case (r.sync2.sel)
					pmhp_pkg::SEL_MODE:
						next_r.mode = r.sync2.data[7:0];          // RL8
					pmhp_pkg::SEL_INDEX:
					begin
						next_r.index = r.sync2.data[7:0];         // RL8
						next_r.ptr = pmhp_pkg::COLOUR_RED;        // RL13
						next_r.low_phase = 1'b0;
					end
					pmhp_pkg::SEL_CONTROL:
					begin
						// writes to unpopulated slots are dropped
						if (r.index < CTRL_LIMIT)
							next_r.ctrl[r.index[3:0]] = r.sync2.data[7:0]; // RL6
					end
					default:
					begin
						value = colour_of(r.hold, r.ptr);         // RL7
						if (wide)
						begin
							value = r.sync2.data;                 // RL19
							done = 1'b1;
						end
						else if (two_cycle && !r.low_phase)
						begin
							value[9:2] = r.sync2.data[7:0];       // RL20
							next_r.low_phase = 1'b1;
						end
						else if (two_cycle)
						begin
							value[1:0] = r.sync2.data[1:0];       // RL20
							next_r.low_phase = 1'b0;
							done = 1'b1;
						end
						else
						begin
							value = {r.sync2.data[7:0], 2'b00};   // RL5
							done = 1'b1;
						end
						// holding keeps partial sets until blue
						next_r.hold = put_colour(r.hold, r.ptr, value); // RL24
					end
				endcase
			end
			else if (r.sync2.sel == pmhp_pkg::SEL_COLOUR)
			begin
				// reads step the same pointer
				if (two_cycle && !r.low_phase)
					next_r.low_phase = 1'b1;                      // RL20
				else
				begin
					next_r.low_phase = 1'b0;
					done = 1'b1;                                  // RL16
				end
			end
		end
		// pointer advance, commit on blue
		if (done)
		begin
			case (r.ptr)
				pmhp_pkg::COLOUR_RED:
					next_r.ptr = pmhp_pkg::COLOUR_GREEN;          // RL12
				pmhp_pkg::COLOUR_GREEN:
					next_r.ptr = pmhp_pkg::COLOUR_BLUE;           // RL12
				default:
				begin
					next_r.ptr = pmhp_pkg::COLOUR_RED;            // RL13
					next_r.index = r.index + 8'h01;               // RL15 RL17
					if (!r.sync2.read_not_write)
					begin
						next_r.we = 1'b1;                         // RL14
						next_r.waddr = r.index;                   // RL14
						next_r.wdata = next_r.hold;               // RL14
					end
				end
			endcase
		end
	end

	// state register, ten-bit port after reset
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.sync1.ce_n <= 1'b1;
			r.sync2.ce_n <= 1'b1;
			r.ce_prev <= 1'b1;
			r.mode <= pmhp_pkg::MODE_RESET;                       // RL11
			r.ctrl <= pmhp_pkg::CTRL_RESET[CTRL_COUNT*8-1:0];
		end
		else
			r <= next_r;
	end

	// palette storage
	pmhp_colour_ram #(
		.DEPTH  (pmhp_pkg::RAM_DEPTH),
		.ADDR_W (pmhp_pkg::INDEX_W),
		.WORD_W (30)
	) u_ram (
		.clock        (clock),
		.rst          (rst),
		.write_enable (r.we),
		.write_addr   (r.waddr),
		.write_word   (r.wdata),
		.read_addr    (read_addr),
		.read_word    (read_word)
	);

	// pixel to look-up index mapping
	pmhp_pixel_map u_map (
		.clock      (clock),
		.rst        (rst),
		.pixel_mode (pixel_mode),
		.pixel_in   (pixel_in),
		.lut_index  (lut_index)
	);

	assign data_out     = r.data_out;
	assign data_oe      = r.data_oe;
	assign dac_out      = r.dac;
	assign mode_control = r.mode;

	property p_blue_write_steps;
		@(posedge clock) disable iff (rst)
		r.we |-> r.index == r.waddr + 8'h01 && r.ptr == pmhp_pkg::COLOUR_RED;
	endproperty
	a_blue_write_steps: assert property (p_blue_write_steps) else $error("index or pointer wrong after blue"); // RL15

	property p_word_joined;
		@(posedge clock) disable iff (rst)
		r.we |-> r.wdata == r.hold;
	endproperty
	a_word_joined: assert property (p_word_joined) else $error("stored word differs from holding"); // RL14

	property p_index_write;
		@(posedge clock) disable iff (rst)
		strobe_rise && !r.sync2.read_not_write && r.sync2.sel == pmhp_pkg::SEL_INDEX
		|=> r.index == $past(r.sync2.data[7:0]) && r.ptr == pmhp_pkg::COLOUR_RED && !r.we;
	endproperty
	a_index_write: assert property (p_index_write) else $error("index write did not reset pointer"); // RL13

	property p_drive_only_read;
		@(posedge clock) disable iff (rst)
		data_oe |-> r.sync2.read_not_write && !r.ce_prev;
	endproperty
	a_drive_only_read: assert property (p_drive_only_read) else $error("bus driven outside a read"); // RL10

	property p_narrow_upper_zero;
		@(posedge clock) disable iff (rst)
		data_oe && !bus_ten |-> data_out[9:8] == 2'b00;
	endproperty
	a_narrow_upper_zero: assert property (p_narrow_upper_zero) else $error("upper lines set in narrow mode"); // RL21

	property p_mode_read;
		@(posedge clock) disable iff (rst)
		strobe_fall && r.sync2.read_not_write && r.sync2.sel == pmhp_pkg::SEL_MODE
		|=> data_oe && data_out == {2'b00, $past(r.mode)};
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode read returned wrong data"); // RL8

	property p_first_half_holds;
		@(posedge clock) disable iff (rst)
		strobe_rise && two_cycle && !r.low_phase && r.sync2.sel == pmhp_pkg::SEL_COLOUR
		|=> r.low_phase && r.ptr == $past(r.ptr) && !r.we;
	endproperty
	a_first_half_holds: assert property (p_first_half_holds) else $error("8+2 first half moved pointer"); // RL20

	property p_blue_read_steps;
		@(posedge clock) disable iff (rst)
		strobe_rise && r.sync2.read_not_write && r.sync2.sel == pmhp_pkg::SEL_COLOUR
		&& r.ptr == pmhp_pkg::COLOUR_BLUE && !(two_cycle && !r.low_phase)
		|=> r.index == $past(r.index) + 8'h01 && !r.we;
	endproperty
	a_blue_read_steps: assert property (p_blue_read_steps) else $error("index did not step after blue read"); // RL17

	property p_low_bits_cleared;
		@(posedge clock) disable iff (rst)
		!res_ten ##1 !res_ten |-> dac_out.red[1:0] == 2'b00 && dac_out.green[1:0] == 2'b00
			&& dac_out.blue[1:0] == 2'b00;
	endproperty
	a_low_bits_cleared: assert property (p_low_bits_cleared) else $error("low converter bits not cleared"); // RL22

endmodule

//--- pmhp_host_model.sv
`timescale 1ns/1ns
module pmhp_host_model (
	input  wire logic                    clock,
	input  wire logic [pmhp_pkg::DATA_W-1:0] data_out,
	input  wire logic                    data_oe,
	output pmhp_pkg::pmhp_bus_type       bus_pins,
	output logic                         hung
);
	logic       ce_n  = 1'b1;    // strobe, idle high
	logic       rnw   = 1'b1;    // direction, high reads
	logic [1:0] sel   = 2'h0;    // register select pair
	logic [9:0] wdata = 10'h000; // write data from the host
	logic       drive = 1'b0;    // host owns the data lines
	logic [9:0] last  = 10'h000; // last level seen on the lines

	initial hung = 1'b0;

	// wire level: device when it drives, host on writes, else a toggling pattern
	// an unknown enable before reset counts as released, so the idle pattern never latches unknown
	assign bus_pins = {ce_n, rnw, sel, (data_oe === 1'b1) ? data_out : drive ? wdata : ~last};

	// keep the last level so a released line never holds still
	always @(posedge clock)
		last <= bus_pins.data;

	// one strobe: low for at least four clocks, then high with qualifiers held
	task automatic xfer(input logic r, input logic [1:0] s, input logic [9:0] d, output logic [9:0] q);
		int n;
		q = 10'h000;
		@(posedge clock);
		rnw   <= r;
		sel   <= s;
		wdata <= d;
		drive <= ~r;
		ce_n  <= 1'b0;
		for (n = 0; n < 8; n++)
		begin
			@(posedge clock);
			// reads wait for the device to drive, writes just hold
			if (n >= 3 && (!r || data_oe === 1'b1))
				break;
		end
		q = data_out;
		if (n == 8)
			hung <= 1'b1;
		ce_n <= 1'b1;
		// select, direction and data stay put while the rise is taken
		repeat (4) @(posedge clock);
		drive <= 1'b0;
	endtask
endmodule

//--- palette_mpu_host_port_tb.sv
`timescale 1ns/1ns
module palette_mpu_host_port_tb;
	logic                          clock        = 1'b0;
	logic                          rst          = 1'b1;
	pmhp_pkg::pmhp_bus_type        bus_pins;
	logic [pmhp_pkg::DATA_W-1:0]   data_out;
	logic                          data_oe;
	pmhp_pkg::pmhp_pixel_mode_type pixel_mode   = pmhp_pkg::PIX_TRUE24;
	pmhp_pkg::pmhp_pixel_type      pixel_in     = 24'h000000;
	pmhp_pkg::pmhp_rgb_type        dac_out;
	logic [7:0]                    mode_control;
	logic                          hung;
	int                            fail_count   = 0;
	int                            compares     = 0;

	// 4 ns clock
	initial
		forever #2 clock = ~clock;

	pmhp_host_port pmhp_host_port_i (
		.clock        (clock),
		.rst          (rst),
		.bus_pins     (bus_pins),
		.data_out     (data_out),
		.data_oe      (data_oe),
		.pixel_mode   (pixel_mode),
		.pixel_in     (pixel_in),
		.dac_out      (dac_out),
		.mode_control (mode_control)
	);

	pmhp_host_model pmhp_host_model_i (
		.clock    (clock),
		.data_out (data_out),
		.data_oe  (data_oe),
		.bus_pins (bus_pins),
		.hung     (hung)
	);

	// palette word pattern: colour code above entry number
	function automatic logic [9:0] col(input logic [7:0] k, input logic [1:0] c);
		return {c, k};
	endfunction

	// compare and count
	task automatic check(input logic [29:0] seen, input logic [29:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic complete_run;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [1:0] s, input logic [9:0] d);
		logic [9:0] unused;
		pmhp_host_model_i.xfer(1'b0, s, d, unused);
	endtask

	task automatic rd(input logic [1:0] s, input logic [9:0] exp);
		logic [9:0] v;
		pmhp_host_model_i.xfer(1'b1, s, 10'h000, v);
		check({20'h00000, v}, {20'h00000, exp});
	endtask

	// set a pixel, wait out the three-stage path, judge the converters
	task automatic px(input pmhp_pkg::pmhp_pixel_mode_type m, input logic [23:0] p, input logic [29:0] exp);
		pixel_mode <= m;
		pixel_in   <= p;
		repeat (6) @(posedge clock);
		check(dac_out, exp);
	endtask

	task automatic t_reset;
		check({22'h000000, mode_control}, 30'h0FF);
		check({29'h00000000, data_oe}, 30'h0);
		rd(pmhp_pkg::SEL_MODE, 10'h0FF);
		rd(pmhp_pkg::SEL_INDEX, 10'h000);
	endtask

	// direct and indexed registers, upper lines dropped
	task automatic t_regs;
		wr(pmhp_pkg::SEL_INDEX, 10'h35A);
		rd(pmhp_pkg::SEL_INDEX, 10'h05A);
		wr(pmhp_pkg::SEL_MODE, 10'h3FE);
		rd(pmhp_pkg::SEL_MODE, 10'h0FE);
		check({22'h000000, mode_control}, 30'h0FE);
		wr(pmhp_pkg::SEL_INDEX, 10'h001);
		rd(pmhp_pkg::SEL_CONTROL, 10'h0FF);
		wr(pmhp_pkg::SEL_INDEX, 10'h003);
		wr(pmhp_pkg::SEL_CONTROL, 10'h3A5);
		rd(pmhp_pkg::SEL_CONTROL, 10'h0A5);
		wr(pmhp_pkg::SEL_INDEX, 10'h009);
		wr(pmhp_pkg::SEL_CONTROL, 10'h055);
		rd(pmhp_pkg::SEL_CONTROL, 10'h000);
	endtask

	// stray red and green, index rewrite, then 33 triples across the wrap
	task automatic t_fill;
		logic [7:0] k;
		int         c;
		wr(pmhp_pkg::SEL_INDEX, 10'h0FF);
		wr(pmhp_pkg::SEL_COLOUR, 10'h111);
		wr(pmhp_pkg::SEL_COLOUR, 10'h222);
		wr(pmhp_pkg::SEL_INDEX, 10'h0FF);
		k = 8'hFF;
		repeat (33)
		begin
			for (c = 1; c < 4; c++)
				wr(pmhp_pkg::SEL_COLOUR, col(k, c[1:0]));
			k++;
		end
		rd(pmhp_pkg::SEL_INDEX, 10'h020);
	endtask

	// partial set leaves entry alone, reads step and wrap the index
	task automatic t_readback;
		int c;
		wr(pmhp_pkg::SEL_INDEX, 10'h010);
		wr(pmhp_pkg::SEL_COLOUR, 10'h3FF);
		wr(pmhp_pkg::SEL_COLOUR, 10'h3FF);
		rd(pmhp_pkg::SEL_INDEX, 10'h010);
		wr(pmhp_pkg::SEL_INDEX, 10'h010);
		for (c = 1; c < 4; c++)
			rd(pmhp_pkg::SEL_COLOUR, col(8'h10, c[1:0]));
		rd(pmhp_pkg::SEL_INDEX, 10'h011);
		wr(pmhp_pkg::SEL_INDEX, 10'h0FF);
		for (c = 1; c < 4; c++)
			rd(pmhp_pkg::SEL_COLOUR, col(8'hFF, c[1:0]));
		rd(pmhp_pkg::SEL_INDEX, 10'h000);
		rd(pmhp_pkg::SEL_COLOUR, col(8'h00, 2'h1));
	endtask

	// every pixel mode, with unused bits set
	task automatic t_pixel;
		px(pmhp_pkg::PIX_TRUE24, 24'h051FFF, {col(8'h05, 2'h1), col(8'h1F, 2'h2), col(8'hFF, 2'h3)});
		px(pmhp_pkg::PIX_PSEUDO, 24'h07AA55, {col(8'h07, 2'h1), col(8'h07, 2'h2), col(8'h07, 2'h3)});
		px(pmhp_pkg::PIX_TRUE15_A, 24'h1F2CFF, {col(8'h03, 2'h1), col(8'h05, 2'h2), col(8'h1F, 2'h3)});
		px(pmhp_pkg::PIX_TRUE15_B, 24'hA3C977, {col(8'h12, 2'h1), col(8'h0D, 2'h2), col(8'h03, 2'h3)});
	endtask

	// narrow bus with ten-bit colour: two strobes per colour
	task automatic t_narrow;
		logic [2:0][9:0] nv;
		int              c;
		nv = {10'h2B7, 10'h1C9, 10'h36E};
		wr(pmhp_pkg::SEL_MODE, 10'h0FA);
		rd(pmhp_pkg::SEL_MODE, 10'h0FA);
		wr(pmhp_pkg::SEL_INDEX, 10'h020);
		for (c = 0; c < 3; c++)
		begin
			wr(pmhp_pkg::SEL_COLOUR, {2'h0, nv[c][9:2]});
			wr(pmhp_pkg::SEL_COLOUR, {8'h00, nv[c][1:0]});
		end
		wr(pmhp_pkg::SEL_INDEX, 10'h020);
		for (c = 0; c < 3; c++)
		begin
			rd(pmhp_pkg::SEL_COLOUR, {2'h0, nv[c][9:2]});
			rd(pmhp_pkg::SEL_COLOUR, {8'h00, nv[c][1:0]});
		end
		px(pmhp_pkg::PIX_TRUE24, 24'h202020, {nv[0], nv[1], nv[2]});
	endtask

	// wide bus with eight-bit colour: one byte, low converter bits cleared
	task automatic t_lowres;
		int c;
		wr(pmhp_pkg::SEL_MODE, 10'h0FC);
		check({22'h000000, mode_control}, 30'h0FC);
		wr(pmhp_pkg::SEL_INDEX, 10'h021);
		for (c = 0; c < 3; c++)
			wr(pmhp_pkg::SEL_COLOUR, 10'h3C6);
		wr(pmhp_pkg::SEL_INDEX, 10'h021);
		for (c = 0; c < 3; c++)
			rd(pmhp_pkg::SEL_COLOUR, 10'h0C6);
		px(pmhp_pkg::PIX_TRUE24, 24'h210521, {10'h318, 10'h204, 10'h318});
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_regs();
		t_fill();
		t_readback();
		t_pixel();
		t_narrow();
		t_lowres();
		complete_run();
	end

	// a strobe that never got its answer ends the run
	always @(posedge clock)
	begin
		if (hung === 1'b1)
		begin
			fail_count++;
			complete_run();
		end
	end
endmodule
